/* rtl/tc_gen_params.svh */
`ifndef TC_GEN_PARAMS_SVH
`define TC_GEN_PARAMS_SVH

// ==========================================================
// Clock and time conversion
`define TC_CLK_PERIOD_NS 20
`define TC_NS_PER_US     1000
`define TC_CYC_PER_US    (`TC_NS_PER_US / `TC_CLK_PERIOD_NS)

// ==========================================================
// Frame moduli and digit limits
`define TC_FPS_24        5'h18
`define TC_FPS_25        5'h19
`define TC_FPS_30        5'h1e
`define TC_SEC_MOD       60
`define TC_MIN_MOD       60
`define TC_HOUR_MOD      24
`define TC_DROP_COUNT    2
`define TC_DROP_EXEMPT   10

// ==========================================================
// Port count and reset values
`define TC_NUM_PORTS     2
`define TC_RST_STATE     '0

`endif

/* rtl/tc_gen_pkg.sv */
`include "tc_gen_params.svh"

package tc_gen_pkg;

  // ==========================================================
  // Modes
  typedef enum logic {
    PER_FRAME = 1'b0,
    PER_FIELD = 1'b1
  } tc_type_t;

  typedef enum logic [1:0] {
    SRC_LOCAL_SAVING = 2'h0,
    SRC_LOCAL_STD    = 2'h1,
    SRC_UTC          = 2'h2,
    SRC_PROGRAM      = 2'h3
  } src_t;

  typedef enum logic [1:0] {
    FMT_24      = 2'h0,
    FMT_25      = 2'h1,
    FMT_30      = 2'h2,
    FMT_30_DROP = 2'h3
  } fmt_t;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [4:0] hours;
    logic [5:0] minutes;
    logic [5:0] seconds;
    logic [4:0] frames;
  } tc_t;

  typedef struct packed {
    logic       neg;
    logic [4:0] hours;
    logic [5:0] minutes;
    logic [5:0] seconds;
    logic [4:0] frames;
  } ofs_t;

  typedef struct packed {
    logic [15:0] year;
    logic [3:0]  month;
    logic [4:0]  day;
  } date_t;

  typedef struct packed {
    logic     stream_en;
    tc_type_t tc_type;
    src_t     src;
    fmt_t     fmt;
    logic     interlaced;
  } cfg_t;

  typedef struct packed {
    logic [10:0]        frame_lines;
    logic [15:0]        line_cycles;
    logic signed [11:0] vdelay;
    logic signed [7:0]  hdelay_us;
  } timing_t;

  typedef struct packed {
    tc_t                tc;
    date_t              date;
    logic signed [10:0] tz_minutes;
    logic               field;
  } pkt_t;

  typedef struct packed {
    logic [10:0]               line;
    logic [15:0]               pix;
    tc_t                       tc;
    pkt_t                      pkt;
    logic                      valid;
    logic [`TC_NUM_PORTS-1:0]  ports;
  } st_t;

endpackage

/* rtl/tc_offset_add.sv */
`timescale 1ns/10ps
`include "tc_gen_params.svh"

module tc_offset_add (
  // Operands
  input  tc_gen_pkg::tc_t   a,
  input  tc_gen_pkg::ofs_t  b,
  input  tc_gen_pkg::fmt_t  fmt,
  // Result
  output tc_gen_pkg::tc_t   y,
  output logic [4:0]        fps
);
  import tc_gen_pkg::*;

  int sg;
  int fr;
  int sc;
  int mn;
  int hr;

  // ==========================================================
  // Signed digit add with carries
  always_comb begin
    case (fmt)
      FMT_24:  fps = `TC_FPS_24;
      FMT_25:  fps = `TC_FPS_25;
      default: fps = `TC_FPS_30;
    endcase
    sg = b.neg ? -1 : 1;
    fr = int'(a.frames) + sg * int'(b.frames);
    sc = int'(a.seconds) + sg * int'(b.seconds);
    mn = int'(a.minutes) + sg * int'(b.minutes);
    hr = int'(a.hours) + sg * int'(b.hours);
    if (fr < 0) begin
      fr = fr + int'(fps);
      sc = sc - 1;
    end else if (fr >= int'(fps)) begin
      fr = fr - int'(fps);
      sc = sc + 1;
    end
    if (sc < 0) begin
      sc = sc + `TC_SEC_MOD;
      mn = mn - 1;
    end else if (sc >= `TC_SEC_MOD) begin
      sc = sc - `TC_SEC_MOD;
      mn = mn + 1;
    end
    if (mn < 0) begin
      mn = mn + `TC_MIN_MOD;
      hr = hr - 1;
    end else if (mn >= `TC_MIN_MOD) begin
      mn = mn - `TC_MIN_MOD;
      hr = hr + 1;
    end
    if (hr < 0) begin
      hr = hr + `TC_HOUR_MOD;
    end else if (hr >= `TC_HOUR_MOD) begin
      hr = hr - `TC_HOUR_MOD;
    end
    if (fmt == FMT_30_DROP && fr < `TC_DROP_COUNT && sc == 0 &&
        (mn % `TC_DROP_EXEMPT) != 0) begin
      fr = `TC_DROP_COUNT;
    end
    y.hours   = 5'(hr);
    y.minutes = 6'(mn);
    y.seconds = 6'(sc);
    y.frames  = 5'(fr);
  end

endmodule

/* rtl/ancillary_time_code_gen.sv */
// Function
// - Packets only while stream enabled and at least one port enabled.
// - Per-frame type emits exactly one value per virtual frame.
// - Per-field type emits one value per field, two per frame.
// - Local with saving: time of day plus zone plus saving offset.
// - Local without saving: time of day plus zone offset only.
// - Universal source: taken directly, no zone or saving correction.
// - Program source: taken from the program time counter.
// - Each value carries h/m/s/f plus year, month, day and zone.
// - Signed user offset of h/m/s/f added before emission.
// - Format selects 24, 25, 30 or 30 drop-frame.
// - 24 format counts frames 00 to 23 then wraps.
// - Drop-frame counts 00 to 29 but omits 00 and 01 at times.
// - Emission timed against a virtual raster of height and rate.
// - Progressive or interlaced scan sets the field structure.
// - Start offset is whole lines plus part line; negative advances.
// - Whole-line delay limited to plus or minus half a frame.
// - Part-line delay in microseconds limited to one line.
`timescale 1ns/10ps
`include "tc_gen_params.svh"

module ancillary_time_code_gen (
  // Clock and reset
  input  wire                        mclk,
  input  wire                        rst_n,
  // Frame reference
  input  wire                        frame_reset,
  input  wire                        jam,
  // Configuration
  input  tc_gen_pkg::cfg_t           cfg,
  input  wire [`TC_NUM_PORTS-1:0]    port_en,
  input  tc_gen_pkg::timing_t        timing,
  input  tc_gen_pkg::ofs_t           user_ofs,
  // Time sources
  input  tc_gen_pkg::tc_t            main_tod,
  input  tc_gen_pkg::tc_t            utc_time,
  input  tc_gen_pkg::tc_t            prog_time,
  input  wire signed [10:0]          tz_minutes,
  input  wire signed [7:0]           daylight_saving_offset,
  input  tc_gen_pkg::date_t          date,
  // Packet output
  output logic                       pkt_valid,
  output logic [`TC_NUM_PORTS-1:0]   pkt_ports,
  output tc_gen_pkg::pkt_t           pkt
);
  import tc_gen_pkg::*;

  st_t                st;
  st_t                next_st;
  tc_t                src_tc;
  tc_t                jam_tc;
  tc_t                inc_tc;
  tc_t                out_tc;
  ofs_t               zone_ofs;
  ofs_t               one_frame;
  logic signed [11:0] zone_min;
  logic [11:0]        zone_abs;
  logic [4:0]         fps;
  logic [10:0]        field2_line;
  logic               frame_start;
  logic               field2_start;
  logic               enabled;
  int                 half;
  int                 lc;
  int                 vd;
  int                 hc;
  int                 ln;
  int                 px;

  // ==========================================================
  // Source selection and zone offset
  always_comb begin
    zone_min = 12'(tz_minutes);
    if (cfg.src == SRC_LOCAL_SAVING) begin
      zone_min = 12'(tz_minutes) + 12'(daylight_saving_offset);
    end
    zone_abs = zone_min[11] ? 12'(-zone_min) : zone_min;
    zone_ofs = '0;
    src_tc   = main_tod;
    unique case (cfg.src)
      SRC_LOCAL_SAVING,
      SRC_LOCAL_STD: begin
        zone_ofs.neg     = zone_min[11];
        zone_ofs.hours   = 5'(zone_abs / 12'(`TC_MIN_MOD));
        zone_ofs.minutes = 6'(zone_abs % 12'(`TC_MIN_MOD));
      end
      SRC_UTC: begin
        src_tc = utc_time;
      end
      SRC_PROGRAM: begin
        src_tc = prog_time;
      end
    endcase
    one_frame        = '0;
    one_frame.frames = 5'h01;
  end

  // ==========================================================
  // Time code arithmetic
  tc_offset_add u_zone (
    .a   (src_tc),
    .b   (zone_ofs),
    .fmt (cfg.fmt),
    .y   (jam_tc),
    .fps ()
  );

  tc_offset_add u_step (
    .a   (st.tc),
    .b   (one_frame),
    .fmt (cfg.fmt),
    .y   (inc_tc),
    .fps (fps)
  );

  tc_offset_add u_user (
    .a   (st.tc),
    .b   (user_ofs),
    .fmt (cfg.fmt),
    .y   (out_tc),
    .fps ()
  );

  // ==========================================================
  // Raster start position after frame reset
  always_comb begin
    half = int'(timing.frame_lines) / 2;
    lc   = int'(timing.line_cycles);
    vd   = int'(timing.vdelay);
    if (vd > half) begin
      vd = half;
    end else if (vd < -half) begin
      vd = -half;
    end
    hc = int'(timing.hdelay_us) * `TC_CYC_PER_US;
    if (hc > lc) begin
      hc = lc;
    end else if (hc < -lc) begin
      hc = -lc;
    end
    px = -hc;
    ln = -vd;
    if (px < 0) begin
      px = px + lc;
      ln = ln - 1;
    end else if (px >= lc && lc > 0) begin
      px = px - lc;
      ln = ln + 1;
    end
    if (ln < 0) begin
      ln = ln + int'(timing.frame_lines);
    end else if (ln >= int'(timing.frame_lines)) begin
      ln = ln - int'(timing.frame_lines);
    end
  end

  // ==========================================================
  // Frame and field edges
  always_comb begin
    if (cfg.interlaced) begin
      field2_line = 11'((timing.frame_lines + 11'h001) >> 1);
    end else begin
      field2_line = timing.frame_lines >> 1;
    end
    frame_start  = st.line == 11'h000 && st.pix == 16'h0000;
    field2_start = st.line == field2_line && st.pix == 16'h0000 &&
                   !frame_start;
    enabled      = cfg.stream_en && (|port_en);
  end

  // ==========================================================
  // Next state
  always_comb begin
    next_st       = st;
    next_st.valid = 1'b0;
    if (frame_reset) begin
      next_st.line = 11'(ln);
      next_st.pix  = 16'(px);
    end else if (int'(st.pix) + 1 >= int'(timing.line_cycles)) begin
      next_st.pix = 16'h0000;
      if (int'(st.line) + 1 >= int'(timing.frame_lines)) begin
        next_st.line = 11'h000;
      end else begin
        next_st.line = st.line + 11'h001;
      end
    end else begin
      next_st.pix = st.pix + 16'h0001;
    end
    if (jam) begin
      next_st.tc = jam_tc;
    end else if (frame_start) begin
      next_st.tc = inc_tc;
    end
    if (enabled && (frame_start ||
        (cfg.tc_type == PER_FIELD && field2_start))) begin
      next_st.valid          = 1'b1;
      next_st.ports          = port_en;
      next_st.pkt.tc         = out_tc;
      next_st.pkt.date       = date;
      next_st.pkt.tz_minutes = tz_minutes;
      next_st.pkt.field      = !frame_start;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st <= `TC_RST_STATE;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Outputs
  assign pkt_valid = st.valid;
  assign pkt_ports = st.ports;
  assign pkt       = st.pkt;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge mclk);
  endclocking

  default disable iff (!rst_n);

  sequence frame_edge;
    st.line == 11'h000 && st.pix == 16'h0000;
  endsequence

  sequence per_frame_req;
    frame_edge ##0 (enabled && cfg.tc_type == PER_FRAME);
  endsequence

  sequence field2_req;
    field2_start ##0 (enabled && cfg.tc_type == PER_FIELD);
  endsequence

  AST_GATE: assert property (
    pkt_valid |-> $past(enabled))
    else $error("packet sent while stream or ports disabled");

  AST_QUIET: assert property (
    !enabled |=> !pkt_valid)
    else $error("packet after disable");

  AST_PER_FRAME: assert property (
    per_frame_req |=> pkt_valid && !pkt.field)
    else $error("frame edge without packet");

  AST_FRAME_ONLY: assert property (
    pkt_valid && $past(cfg.tc_type) == PER_FRAME |->
      $past(st.line) == 11'h000 && $past(st.pix) == 16'h0000)
    else $error("per-frame packet off the frame edge");

  AST_FIELD2: assert property (
    field2_req |=> pkt_valid && pkt.field)
    else $error("second field without packet");

  AST_JAM_UTC: assert property (
    jam && cfg.src == SRC_UTC && cfg.fmt != FMT_30_DROP |=>
      st.tc == $past(utc_time))
    else $error("universal time not taken directly");

  AST_JAM_PROG: assert property (
    jam && cfg.src == SRC_PROGRAM && cfg.fmt != FMT_30_DROP |=>
      st.tc == $past(prog_time))
    else $error("program time not taken directly");

  AST_FMOD: assert property (
    jam |=> st.tc.frames < $past(fps))
    else $error("frame digit beyond format modulus");

  AST_DROP: assert property (
    jam && cfg.fmt == FMT_30_DROP |=>
      !(st.tc.frames < 5'h02 && st.tc.seconds == 6'h00 &&
        (st.tc.minutes % 6'h0a) != 6'h00))
    else $error("dropped frame count present");

  AST_HOURS: assert property (
    jam |=> st.tc.hours < 5'h18)
    else $error("hours not wrapped");

  AST_ZERO_DELAY: assert property (
    frame_reset && timing.vdelay == 12'sh000 &&
      timing.hdelay_us == 8'sh00 |=>
      st.line == 11'h000 && st.pix == 16'h0000)
    else $error("zero delay does not align to frame reset");

  AST_STEP: assert property (
    frame_start && !jam |=> st.tc == $past(inc_tc))
    else $error("counter did not advance on frame edge");

  sequence last_pix;
    int'(st.pix) + 1 >= int'(timing.line_cycles);
  endsequence

  sequence frame_end;
    last_pix ##0 (int'(st.line) + 1 >= int'(timing.frame_lines));
  endsequence

  AST_WRAP: assert property (
    frame_end ##0 !frame_reset |=> frame_edge)
    else $error("raster did not wrap to the frame edge");

  AST_LINE_STEP: assert property (
    last_pix ##0 (int'(st.line) + 1 < int'(timing.frame_lines)) ##0
      !frame_reset |=> st.line == $past(st.line) + 11'h001 &&
      st.pix == 16'h0000)
    else $error("line did not advance at the end of a line");

  AST_LINE_START: assert property (
    pkt_valid |-> $past(st.pix) == 16'h0000)
    else $error("packet not aligned to a line start");

  AST_START: assert property (
    frame_reset |=> st.line < $past(timing.frame_lines) &&
      st.pix < $past(timing.line_cycles))
    else $error("start position outside the raster");

  AST_NO_ZONE: assert property (
    cfg.src == SRC_UTC || cfg.src == SRC_PROGRAM |-> zone_ofs == '0)
    else $error("zone offset applied to a universal or program source");

  AST_PORTS: assert property (
    pkt_valid |-> pkt_ports == $past(port_en) && pkt_ports != '0)
    else $error("packet ports differ from enabled ports");

  AST_PKT_INFO: assert property (
    pkt_valid |-> pkt.date == $past(date) &&
      pkt.tz_minutes == $past(tz_minutes))
    else $error("packet date or zone not carried");

  AST_HOLD: assert property (
    !pkt_valid |-> $stable(pkt) && $stable(pkt_ports))
    else $error("packet contents changed between packets");

  AST_FIELD_ONLY: assert property (
    pkt_valid && pkt.field |-> $past(cfg.tc_type) == PER_FIELD)
    else $error("second-field packet in per-frame type");

endmodule

/* verif/tc_pkt_sink.sv */
`timescale 1ns/10ps
`include "tc_gen_params.svh"

// ==========================================================
// Transmit path model: counts packets, flags portless ones
module tc_pkt_sink (
  // Clock and reset
  input  wire                      mclk,
  input  wire                      rst_n,
  // Packet input
  input  wire                      pkt_valid,
  input  wire [`TC_NUM_PORTS-1:0]  pkt_ports,
  // Observed traffic
  output int                       pkt_count,
  output logic                     bad_ports
);
  import tc_gen_pkg::*;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pkt_count <= 0;
      bad_ports <= 1'b0;
    end else if (pkt_valid) begin
      pkt_count <= pkt_count + 1;
      if (pkt_ports == '0) begin
        bad_ports <= 1'b1;
      end
    end
  end
endmodule

/* verif/ancillary_timecode_generator_bench.sv */
`timescale 1ns/10ps
`include "tc_gen_params.svh"

module ancillary_timecode_generator_bench;
  import tc_gen_pkg::*;

  // ==========================================================
  // Raster of 4 lines of 60 clocks
  localparam int LINE  = 60;
  localparam int FRAME = 4 * LINE;

  logic                     mclk;
  logic                     rst_n;
  logic                     frame_reset;
  logic                     jam;
  cfg_t                     cfg;
  logic [`TC_NUM_PORTS-1:0] port_en;
  timing_t                  timing;
  ofs_t                     user_ofs;
  tc_t                      main_tod;
  tc_t                      utc_time;
  tc_t                      prog_time;
  logic signed [10:0]       tz_minutes;
  logic signed [7:0]        daylight_saving_offset;
  date_t                    date;
  logic                     pkt_valid;
  logic [`TC_NUM_PORTS-1:0] pkt_ports;
  pkt_t                     pkt;
  int                       pkt_count;
  logic                     bad_ports;
  int                       mismatches;
  int                       n_checks;
  int                       n;

  ancillary_time_code_gen i_ancillary_time_code_gen (
    .mclk(mclk), .rst_n(rst_n), .frame_reset(frame_reset), .jam(jam),
    .cfg(cfg), .port_en(port_en), .timing(timing), .user_ofs(user_ofs),
    .main_tod(main_tod), .utc_time(utc_time), .prog_time(prog_time),
    .tz_minutes(tz_minutes), .daylight_saving_offset(daylight_saving_offset),
    .date(date), .pkt_valid(pkt_valid), .pkt_ports(pkt_ports), .pkt(pkt)
  );

  tc_pkt_sink i_tc_pkt_sink (
    .mclk(mclk), .rst_n(rst_n), .pkt_valid(pkt_valid),
    .pkt_ports(pkt_ports), .pkt_count(pkt_count), .bad_ports(bad_ports)
  );

  initial mclk = 1'b0;
  always #10 mclk = ~mclk;

  // ==========================================================
  // Shared tasks
  function automatic tc_t mk(input logic [7:0] h, m, s, f);
    mk = {h[4:0], m[5:0], s[5:0], f[4:0]};
  endfunction

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic pulse(input logic do_jam);
    @(negedge mclk);
    frame_reset = 1'b1;
    jam         = do_jam;
    @(negedge mclk);
    frame_reset = 1'b0;
    jam         = 1'b0;
  endtask

  // Edges from the frame reset edge to the packet
  task automatic wait_pkt;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (pkt_valid !== 1'b1 && n < 1000);
    if (n >= 1000) begin
      $display("MISMATCH pkt_valid expected 1 seen none");
      mismatches++;
      finish_test();
    end
  endtask

  task automatic quiet;
    int c;
    c = pkt_count;
    pulse(1'b0);
    repeat (FRAME + LINE) @(negedge mclk);
    check("pkt_count", c, pkt_count);
  endtask

  task automatic count_win(input int exp);
    int c;
    @(negedge mclk);
    c = pkt_count;
    repeat (3 * FRAME - LINE - 1) @(negedge mclk);
    check("pkt_count", c + exp, pkt_count);
  endtask

  task automatic run_fmt(input fmt_t f, input tc_t src, input ofs_t ofs,
                         input tc_t e1, input tc_t e2, input logic chk2);
    cfg.fmt  = f;
    utc_time = src;
    user_ofs = ofs;
    pulse(1'b1);
    wait_pkt();
    check("pkt.tc", e1, pkt.tc);
    if (chk2) begin
      wait_pkt();
      check("pkt.tc next", e2, pkt.tc);
    end
  endtask

  task automatic run_dly(input int v, input int h, input int exp);
    timing.vdelay    = 12'(v);
    timing.hdelay_us = 8'(h);
    pulse(1'b0);
    wait_pkt();
    check("latency", exp, n);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_gate;
    cfg.stream_en = 1'b0;
    quiet();
    cfg.stream_en = 1'b1;
    port_en       = 2'h0;
    quiet();
    port_en = 2'h2;
    pulse(1'b0);
    wait_pkt();
    check("latency", 32'h1, n);
    check("pkt_ports", 32'h2, pkt_ports);
    check("bad_ports", 32'h0, bad_ports);
    $display("test gate done");
  endtask

  task automatic t_rate;
    pulse(1'b0);
    wait_pkt();
    check("field", 32'h0, pkt.field);
    count_win(2);
    cfg.tc_type    = PER_FIELD;
    cfg.interlaced = 1'b1;
    pulse(1'b0);
    wait_pkt();
    check("field", 32'h0, pkt.field);
    wait_pkt();
    check("field gap", 2 * LINE, n);
    check("field", 32'h1, pkt.field);
    wait_pkt();
    check("field", 32'h0, pkt.field);
    count_win(5);
    cfg.tc_type    = PER_FRAME;
    cfg.interlaced = 1'b0;
    $display("test rate done");
  endtask

  task automatic t_src;
    tc_t exp [4];
    exp[0]    = mk(8'h0b, 8'h32, 8'h1e, 8'h05);
    exp[1]    = mk(8'h0b, 8'h14, 8'h1e, 8'h05);
    exp[2]    = mk(8'h03, 8'h04, 8'h05, 8'h06);
    exp[3]    = mk(8'h07, 8'h08, 8'h09, 8'h0a);
    main_tod  = mk(8'h0a, 8'h14, 8'h1e, 8'h05);
    utc_time  = exp[2];
    prog_time = exp[3];
    for (int s = 0; s < 4; s++) begin
      cfg.src = src_t'(s);
      pulse(1'b1);
      wait_pkt();
      check("pkt.tc", exp[s], pkt.tc);
      check("pkt.date", date, pkt.date);
      check("pkt.tz", tz_minutes, pkt.tz_minutes);
    end
    $display("test source done");
  endtask

  task automatic t_fmt;
    cfg.src = SRC_UTC;
    run_fmt(FMT_24, mk(8'h17, 8'h3b, 8'h3b, 8'h17), '0,
            mk(8'h17, 8'h3b, 8'h3b, 8'h17), '0, 1'b1);
    run_fmt(FMT_25, '0, {1'b1, mk(8'h00, 8'h00, 8'h00, 8'h01)},
            mk(8'h17, 8'h3b, 8'h3b, 8'h18), '0, 1'b1);
    run_fmt(FMT_30, mk(8'h00, 8'h00, 8'h3b, 8'h1d),
            {1'b0, mk(8'h01, 8'h00, 8'h00, 8'h01)},
            mk(8'h01, 8'h01, 8'h00, 8'h00),
            mk(8'h01, 8'h01, 8'h00, 8'h01), 1'b1);
    run_fmt(FMT_30_DROP, mk(8'h00, 8'h00, 8'h3b, 8'h1d), '0,
            mk(8'h00, 8'h00, 8'h3b, 8'h1d),
            mk(8'h00, 8'h01, 8'h00, 8'h02), 1'b1);
    run_fmt(FMT_30_DROP, mk(8'h00, 8'h09, 8'h3b, 8'h1d), '0,
            mk(8'h00, 8'h09, 8'h3b, 8'h1d),
            mk(8'h00, 8'h0a, 8'h00, 8'h00), 1'b1);
    run_fmt(FMT_30_DROP, mk(8'h00, 8'h01, 8'h3b, 8'h1d),
            {1'b0, mk(8'h00, 8'h00, 8'h00, 8'h01)},
            mk(8'h00, 8'h02, 8'h00, 8'h02), '0, 1'b0);
    user_ofs = '0;
    $display("test format done");
  endtask

  task automatic t_delay;
    run_dly(1, 0, 1 + LINE);
    run_dly(-1, 0, 1 + 3 * LINE);
    run_dly(3, 0, 1 + 2 * LINE);
    run_dly(-3, 0, 1 + 2 * LINE);
    run_dly(0, 1, 1 + `TC_CYC_PER_US);
    run_dly(0, -1, 1 + 4 * LINE - `TC_CYC_PER_US);
    run_dly(0, 2, 1 + LINE);
    run_dly(0, 0, 1);
    $display("test delay done");
  endtask

  // Odd frame height: second field line depends on scan type
  task automatic t_scan;
    timing.frame_lines = 11'h5;
    cfg.tc_type        = PER_FIELD;
    for (int i = 0; i < 2; i++) begin
      cfg.interlaced = i[0];
      pulse(1'b0);
      wait_pkt();
      wait_pkt();
      check("field gap", (2 + i) * LINE, n);
      check("field", 32'h1, pkt.field);
    end
    $display("test scan done");
  endtask

  initial begin
    rst_n                  = 1'b0;
    frame_reset            = 1'b0;
    jam                    = 1'b0;
    cfg                    = '{1'b1, PER_FRAME, SRC_UTC, FMT_30, 1'b0};
    port_en                = 2'h3;
    timing                 = '{11'h4, 16'h3c, 12'h0, 8'h0};
    user_ofs               = '0;
    main_tod               = '0;
    utc_time               = '0;
    prog_time              = '0;
    tz_minutes             = 11'h3c;
    daylight_saving_offset = 8'h1e;
    date                   = '{16'h07e8, 4'h6, 5'h0f};
    mismatches             = 0;
    n_checks               = 0;
    repeat (12) @(negedge mclk);
    rst_n = 1'b1;
    t_gate();
    t_rate();
    t_src();
    t_fmt();
    t_delay();
    t_scan();
    finish_test();
  end
endmodule
